// ---- rtl/lnbt_tone_volt_sel.v ----
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lnbt_regs.vh"

// ****************************************
// lnb tone and voltage select
// ****************************************
// Functional notes
// - two strap pins pick one of four bus slave addresses
// - tone bits low: envelope pin gates internal tone onto output
// - continuous bit high: steady 22kHz tone, envelope pin ignored
// - modulation select high, continuous bit low: envelope pin tone passed straight through
// - converter clock is twenty times tone; tone is that divided by twenty
// - fault pin is open drain, low on fault, released when normal
// - pin mode, range pin low: low range, level from low-range bit
// - pin mode, range pin high: high range, level from high-range bit
// - pin-override-off bit high: range pin ignored, bits alone decide
// - tone detected pulls the open-drain found output low
// - txrx pin low picks receive threshold, high picks transmit
// - each channel enable bit gates its own converter
// - undervoltage lockout holds the block in reset
// - registers steer everything, read back, and report diagnostics
// - fault also on overcurrent, back current, overheat, both channels off
// - every control bit comes up cleared after power loss
// - threshold bit high drives the txrx pin high
module lnbt_tone_volt_sel (
   // clock, reset, enable
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire       clkEn,
   // register port
   input  wire [2:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWrStb,
   input  wire       regRdStb,
   output wire [7:0] regRdData,
   // address straps
   input  wire       slaveSelStrap0,
   input  wire       slaveSelStrap1,
   output wire [6:0] slaveAddr,
   // tone envelope / external tone
   input  wire       toneEnvelopeInA,
   input  wire       toneEnvelopeInB,
   // range select pins
   input  wire       rangePinA,
   input  wire       rangePinB,
   // tone decoder comparator results
   input  wire       toneDetectInA,
   input  wire       toneDetectInB,
   // txrx threshold pins
   input  wire       txrxThreshPinInA,
   input  wire       txrxThreshPinInB,
   output wire       txrxThreshPinOutA,
   output wire       txrxThreshPinOutB,
   output wire       txrxThreshPinOeA,
   output wire       txrxThreshPinOeB,
   // analog fault flags
   input  wire       overCurrentA,
   input  wire       overCurrentB,
   input  wire       backCurrentA,
   input  wire       backCurrentB,
   input  wire       overTemp,
   // tone found, open drain
   output wire       toneFoundNOutA,
   output wire       toneFoundNOutB,
   output wire       toneFoundNOeA,
   output wire       toneFoundNOeB,
   // fault line, open drain
   output wire       faultIrqNOut,
   output wire       faultIrqNOe,
   // analog controls
   output wire       boostClk,
   output wire       toneOutA,
   output wire       toneOutB,
   output wire       pwmOnA,
   output wire       pwmOnB,
   output wire [1:0] levelCodeA,
   output wire [1:0] levelCodeB,
   output wire       threshHighA,
   output wire       threshHighB
);

   // ****************************************
   // timing
   // ****************************************
   // half period of converter clock, rounded down
   localparam integer BOOST_HALF =
      `LNBT_SYS_CLK_HZ / (2 * `LNBT_TONE_HZ * `LNBT_BOOST_MULT);
   // counts cut to counter width on purpose, both fit with room to spare
   localparam integer BOOST_LAST_I = BOOST_HALF - 1;
   localparam integer TONE_LAST_I  = (`LNBT_BOOST_MULT / 2) - 1;
   localparam [5:0]   BOOST_LAST   = BOOST_LAST_I[5:0];
   localparam [4:0]   TONE_LAST    = TONE_LAST_I[4:0];

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam NSYNC = 15;
   wire [NSYNC-1:0] asyncIn;
   reg  [NSYNC-1:0] sync1_q;
   reg  [NSYNC-1:0] sync2_q;

   assign asyncIn = {slaveSelStrap1, slaveSelStrap0, overTemp,
                     backCurrentB, backCurrentA, overCurrentB, overCurrentA,
                     txrxThreshPinInB, txrxThreshPinInA,
                     toneDetectInB, toneDetectInA,
                     rangePinB, rangePinA,
                     toneEnvelopeInB, toneEnvelopeInA};

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= {NSYNC{1'b0}};
         sync2_q <= {NSYNC{1'b0}};
      end else if (clkEn) begin
         sync1_q <= asyncIn;
         sync2_q <= sync1_q;
      end
   end

   wire [1:0] envS   = sync2_q[1:0];
   wire [1:0] rngS   = sync2_q[3:2];
   wire [1:0] tdinS  = sync2_q[5:4];
   wire [1:0] txpS   = sync2_q[7:6];
   wire [1:0] ocS    = sync2_q[9:8];
   wire [1:0] bcS    = sync2_q[11:10];
   wire       otS    = sync2_q[12];
   wire [1:0] strapS = sync2_q[14:13];

   // ****************************************
   // control registers
   // ****************************************
   reg  [7:0] ctlA_q;
   reg  [7:0] ctlB_q;
   reg  [7:0] rdData_q;
   wire [7:0] statusW;
   wire [1:0] foundW;

   // undervoltage lockout arrives as rstn
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctlA_q <= `LNBT_CTL_RESET;
         ctlB_q <= `LNBT_CTL_RESET;
      end else if (clkEn && regWrStb) begin
         if (regAddr == `LNBT_REG_CTL_A) begin
            ctlA_q <= regWrData;
         end else if (regAddr == `LNBT_REG_CTL_B) begin
            ctlB_q <= regWrData;
         end
      end
   end

   assign statusW = {1'b0, foundW[1], foundW[0], otS,
                     bcS[1], ocS[1], bcS[0], ocS[0]};

   // read data stands for one cycle only, zero otherwise
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdData_q <= 8'h00;
      end else if (clkEn) begin
         if (!regRdStb) begin
            rdData_q <= 8'h00;
         end else if (regAddr == `LNBT_REG_CTL_A) begin
            rdData_q <= ctlA_q;
         end else if (regAddr == `LNBT_REG_CTL_B) begin
            rdData_q <= ctlB_q;
         end else if (regAddr == `LNBT_REG_STATUS) begin
            rdData_q <= statusW;
         end else if (regAddr == `LNBT_REG_SLAVE) begin
            rdData_q <= {1'b0, slaveAddr};
         end else begin
            rdData_q <= 8'h00;
         end
      end
   end

   assign regRdData = rdData_q;

   // ****************************************
   // slave address straps
   // ****************************************
   // straps are caught once, after the synchroniser has filled
   reg [1:0] strapWait_q;
   reg [6:0] slave_q;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strapWait_q <= 2'h0;
         slave_q     <= `LNBT_SLAVE_BASE;
      end else if (clkEn && strapWait_q != 2'h3) begin
         strapWait_q <= strapWait_q + 2'h1;
         if (strapWait_q == 2'h2) begin
            slave_q <= `LNBT_SLAVE_BASE | {5'h00, strapS};
         end
      end
   end

   assign slaveAddr = slave_q;

   // ****************************************
   // converter clock and tone divider
   // ****************************************
   reg [5:0] boostCnt_q;
   reg       boostClk_q;
   reg [4:0] toneCnt_q;
   reg       tone_q;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         boostCnt_q <= 6'h00;
         boostClk_q <= 1'b0;
         toneCnt_q  <= 5'h00;
         tone_q     <= 1'b0;
      end else if (clkEn) begin
         if (boostCnt_q == BOOST_LAST) begin
            boostCnt_q <= 6'h00;
            boostClk_q <= ~boostClk_q;
            // one tone half period per ten converter periods
            if (!boostClk_q) begin
               if (toneCnt_q == TONE_LAST) begin
                  toneCnt_q <= 5'h00;
                  tone_q    <= ~tone_q;
               end else begin
                  toneCnt_q <= toneCnt_q + 5'h01;
               end
            end
         end else begin
            boostCnt_q <= boostCnt_q + 6'h01;
         end
      end
   end

   assign boostClk = boostClk_q;

   // ****************************************
   // level code
   // ****************************************
   // range in [1], upper level of that range in [0]; with the override
   // off the high-level bit picks the range and the low-level bit the
   // level, so all four levels stay reachable without the range pin
   function [1:0] level_code;
      input pOff;
      input rPin;
      input hBit;
      input lBit;
      reg   hRng;
      begin
         // pin only counts while the override-off bit is low
         hRng = pOff ? hBit : rPin;
         if (pOff) begin
            level_code = {hRng, lBit};
         end else begin
            level_code = {hRng, hRng ? hBit : lBit};
         end
      end
   endfunction

   // ****************************************
   // per channel logic
   // ****************************************
   reg [1:0] toneOut_q;
   reg [1:0] found_q;
   reg [1:0] pwmOn_q;
   reg [1:0] thrHigh_q;
   reg [1:0] txOe_q;
   reg [3:0] level_q;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
         wire [7:0] ctl = (ch == 0) ? ctlA_q : ctlB_q;
         wire       pinOff = ctl[`LNBT_CTL_PINOFF];
         wire       hiBit  = ctl[`LNBT_CTL_HIGHLVL];
         wire       loBit  = ctl[`LNBT_CTL_LOWLVL];
         wire [1:0] lvlCode;

         assign lvlCode = level_code(pinOff, rngS[ch], hiBit, loBit);

         always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               toneOut_q[ch]         <= 1'b0;
               found_q[ch]           <= 1'b0;
               pwmOn_q[ch]           <= 1'b0;
               thrHigh_q[ch]         <= 1'b0;
               txOe_q[ch]            <= 1'b0;
               level_q[2*ch+1:2*ch]  <= 2'h0;
            end else if (clkEn) begin
               // continuous bit wins over both pin modes
               if (ctl[`LNBT_CTL_CONT]) begin
                  toneOut_q[ch] <= tone_q;
               end else if (ctl[`LNBT_CTL_EXTMOD]) begin
                  toneOut_q[ch] <= envS[ch];
               end else begin
                  toneOut_q[ch] <= envS[ch] & tone_q;
               end
               found_q[ch]          <= tdinS[ch];
               pwmOn_q[ch]          <= ctl[`LNBT_CTL_ON];
               txOe_q[ch]           <= ctl[`LNBT_CTL_THRESH];
               // own drive counts at once, pin level after sync
               thrHigh_q[ch] <= ctl[`LNBT_CTL_THRESH] | txpS[ch];
               level_q[2*ch+1:2*ch] <= lvlCode;
            end
         end
      end
   endgenerate

   assign foundW = found_q;

   // ****************************************
   // fault line
   // ****************************************
   reg faultOe_q;

   // reset clears both enables, so the line pulls low from reset
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         faultOe_q <= 1'b1;
      end else if (clkEn) begin
         faultOe_q <= (|ocS) | (|bcS) | otS |
                      ~(ctlA_q[`LNBT_CTL_ON] | ctlB_q[`LNBT_CTL_ON]);
      end
   end

   // ****************************************
   // output wiring
   // ****************************************
   assign faultIrqNOut      = 1'b0;
   assign faultIrqNOe       = faultOe_q;
   assign toneFoundNOutA    = 1'b0;
   assign toneFoundNOutB    = 1'b0;
   assign toneFoundNOeA     = found_q[0];
   assign toneFoundNOeB     = found_q[1];
   assign txrxThreshPinOutA = 1'b1;
   assign txrxThreshPinOutB = 1'b1;
   assign txrxThreshPinOeA  = txOe_q[0];
   assign txrxThreshPinOeB  = txOe_q[1];
   assign toneOutA          = toneOut_q[0];
   assign toneOutB          = toneOut_q[1];
   assign pwmOnA            = pwmOn_q[0];
   assign pwmOnB            = pwmOn_q[1];
   assign levelCodeA        = level_q[1:0];
   assign levelCodeB        = level_q[3:2];
   assign threshHighA       = thrHigh_q[0];
   assign threshHighB       = thrHigh_q[1];

endmodule // lnbt_tone_volt_sel

// ---- rtl/lnbt_regs.vh ----
`ifndef LNBT_REGS_VH
`define LNBT_REGS_VH

// ****************************************
// register indices (3-bit address)
// ****************************************
`define LNBT_REG_CTL_A    3'h0
`define LNBT_REG_CTL_B    3'h1
`define LNBT_REG_STATUS   3'h2
`define LNBT_REG_SLAVE    3'h3

// ****************************************
// control register fields
// ****************************************
`define LNBT_CTL_ON       0
`define LNBT_CTL_CONT     1
`define LNBT_CTL_EXTMOD   2
`define LNBT_CTL_HIGHLVL  3
`define LNBT_CTL_LOWLVL   4
`define LNBT_CTL_PINOFF   5
`define LNBT_CTL_THRESH   6
`define LNBT_CTL_RESET    8'h00

// ****************************************
// status register fields
// ****************************************
`define LNBT_ST_OC_A      0
`define LNBT_ST_BC_A      1
`define LNBT_ST_OC_B      2
`define LNBT_ST_BC_B      3
`define LNBT_ST_OT        4
`define LNBT_ST_TONE_A    5
`define LNBT_ST_TONE_B    6

// ****************************************
// bus slave address and timing
// ****************************************
`define LNBT_SLAVE_BASE   7'h08
`define LNBT_SYS_CLK_HZ   40000000
`define LNBT_TONE_HZ      22000
`define LNBT_BOOST_MULT   20

`endif

// ---- verification/lnbt_checker_assertions.sv ----
`timescale 1ns/1ps
// ****************************************
// port checks on the select block
// ****************************************
module lnbt_checker (
   // clock, reset, enable
   input logic       clk_sys,
   input logic       rstn,
   input logic       clkEn,
   // register port
   input logic [2:0] regAddr,
   input logic [7:0] regWrData,
   input logic       regWrStb,
   input logic       regRdStb,
   input logic [7:0] regRdData,
   // pins
   input logic       slaveSelStrap0,
   input logic       slaveSelStrap1,
   input logic [6:0] slaveAddr,
   input logic       toneDetectInA,
   input logic       overTemp,
   input logic       toneFoundNOutA,
   input logic       toneFoundNOeA,
   input logic       faultIrqNOut,
   input logic       faultIrqNOe,
   input logic       txrxThreshPinOutA,
   input logic       txrxThreshPinOeA,
   input logic       pwmOnA,
   input logic       pwmOnB,
   input logic       threshHighA
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   sequence s_wrA;
      regWrStb && clkEn && regAddr == 3'h0;
   endsequence
   sequence s_otHeld;
      (clkEn && overTemp)[*4];
   endsequence
   property p_rd_idle;
      $past(clkEn) && !$past(regRdStb) |-> regRdData == 8'h00;
   endproperty
   property p_ctl_a;
      s_wrA |-> ##2 (pwmOnA == $past(regWrData[0], 2) && txrxThreshPinOeA == $past(regWrData[6], 2));
   endproperty
   property p_both_off;
      !pwmOnA && !pwmOnB |-> faultIrqNOe;
   endproperty
   property p_over_temp;
      s_otHeld |-> faultIrqNOe;
   endproperty
   property p_od_const;
      faultIrqNOut == 1'b0 && toneFoundNOutA == 1'b0 && txrxThreshPinOutA == 1'b1;
   endproperty
   property p_tone_found;
      (clkEn && $stable(toneDetectInA))[*4] |-> toneFoundNOeA == toneDetectInA;
   endproperty
   property p_thresh;
      txrxThreshPinOeA |-> threshHighA;
   endproperty
   property p_slave;
      (clkEn && $stable({slaveSelStrap1, slaveSelStrap0}))[*4]
         |-> slaveAddr == {5'h02, slaveSelStrap1, slaveSelStrap0};
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
   a_ctl_a: assert property (p_ctl_a) else $error("control write not applied");
   a_both_off: assert property (p_both_off) else $error("fault missing, both off");
   a_over_temp: assert property (p_over_temp) else $error("fault missing, overheat");
   a_od_const: assert property (p_od_const) else $error("open drain level wrong");
   a_tone_found: assert property (p_tone_found) else $error("tone found wrong");
   a_thresh: assert property (p_thresh) else $error("threshold not high");
   a_slave: assert property (p_slave) else $error("slave address wrong");
endmodule // lnbt_checker

bind lnbt_tone_volt_sel lnbt_checker u_chk (.*);

// ---- verification/lnbt_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host on the register port
// ****************************************
module lnbt_host_model (
   // clock
   input  logic       clk_sys,
   // register port
   output logic [2:0] regAddr,
   output logic [7:0] regWrData,
   output logic       regWrStb,
   output logic       regRdStb,
   input  logic [7:0] regRdData,
   // fault line level
   input  logic       faultIrqN
);
   initial begin
      regAddr = 3'h0;
      regWrData = 8'h00;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
   end
   // released address and data show the inverse, not the last value
   task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
   task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      regAddr <= ~a;
      @(negedge clk_sys);
      d = regRdData;
   endtask
   task automatic service_fault(output logic [7:0] st);
      st = 8'h00;
      if (faultIrqN === 1'b0) read_reg(3'h2, st);
   endtask
endmodule // lnbt_host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, rstn, clkEn, t, b;
   logic [14:0] pin;
   logic [1:0]  strap;
   logic [7:0]  cA, cB, rd;
   logic [7:0]  corner [6] = '{8'h00, 8'h29, 8'h39, 8'h19, 8'h04, 8'hff};
   int          seed, errors, comparisons, n, nb;
   wire [2:0]   regAddr;
   wire [7:0]   regWrData, regRdData;
   wire [6:0]   slaveAddr;
   wire [1:0]   levelCodeA, levelCodeB;
   wire         regWrStb, regRdStb, txOutA, txOutB, txOeA, txOeB, tfOutA, tfOutB, tfOeA, tfOeB;
   wire         fOut, fOe, boostClk, toneOutA, toneOutB, pwmOnA, pwmOnB, threshHighA, threshHighB;
   wire         txPinA = txOeA ? txOutA : pin[8];
   wire         txPinB = txOeB ? txOutB : pin[9];
   wire         faultN = fOe ? fOut : 1'b1;
   lnbt_host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .faultIrqN(faultN));
   lnbt_tone_volt_sel DUT (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .slaveSelStrap0(pin[0]), .slaveSelStrap1(pin[1]), .slaveAddr(slaveAddr),
      .toneEnvelopeInA(pin[2]), .toneEnvelopeInB(pin[3]), .rangePinA(pin[4]), .rangePinB(pin[5]),
      .toneDetectInA(pin[6]), .toneDetectInB(pin[7]), .txrxThreshPinInA(txPinA),
      .txrxThreshPinInB(txPinB), .txrxThreshPinOutA(txOutA), .txrxThreshPinOutB(txOutB),
      .txrxThreshPinOeA(txOeA), .txrxThreshPinOeB(txOeB), .overCurrentA(pin[10]),
      .overCurrentB(pin[11]), .backCurrentA(pin[12]), .backCurrentB(pin[13]), .overTemp(pin[14]),
      .toneFoundNOutA(tfOutA), .toneFoundNOutB(tfOutB), .toneFoundNOeA(tfOeA),
      .toneFoundNOeB(tfOeB), .faultIrqNOut(fOut), .faultIrqNOe(fOe), .boostClk(boostClk),
      .toneOutA(toneOutA), .toneOutB(toneOutB), .pwmOnA(pwmOnA), .pwmOnB(pwmOnB),
      .levelCodeA(levelCodeA), .levelCodeB(levelCodeB), .threshHighA(threshHighA),
      .threshHighB(threshHighB));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   function automatic logic [1:0] level_exp(input logic [7:0] c, input logic rng);
      return c[5] ? {c[3], c[4]} : {rng, rng ? c[3] : c[4]};
   endfunction
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check_all;
      logic [7:0] st;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      check_val("pwmA", cA[0], pwmOnA);
      check_val("pwmB", cB[0], pwmOnB);
      check_val("levelA", level_exp(cA, pin[4]), levelCodeA);
      check_val("levelB", level_exp(cB, pin[5]), levelCodeB);
      check_val("fault", (|pin[14:10]) | !(cA[0] | cB[0]), fOe);
      check_val("foundB", pin[7], tfOeB);
      check_val("threshA", {cA[6] | pin[8], cA[6]}, {threshHighA, txOeA});
      check_val("threshB", {cB[6] | pin[9], cB[6]}, {threshHighB, txOeB});
      check_val("slave", {5'h02, pin[1:0]}, slaveAddr);
      check_val("odConst", 5'h03, {fOut, tfOutA, tfOutB, txOutA, txOutB});
      if (!cA[1] && (cA[2] || !pin[2])) check_val("toneA", cA[2] & pin[2], toneOutA);
      if (!cB[1] && (cB[2] || !pin[3])) check_val("toneB", cB[2] & pin[3], toneOutB);
      host.read_reg(3'h0, st);
      check_val("ctlA", cA, st);
      host.read_reg(3'h1, st);
      check_val("ctlB", cB, st);
      host.service_fault(st);
      if (fOe === 1'b1) check_val("status", {1'b0, pin[7:6], pin[14:13], pin[11], pin[12], pin[10]}, st);
   endtask
   task automatic wait_toggle(output int cyc, output int edges);
      cyc = 0;
      edges = 0;
      t = toneOutA;
      b = boostClk;
      while (toneOutA === t && cyc < 4000) begin
         @(negedge clk_sys);
         cyc++;
         if (boostClk !== b) edges++;
         b = boostClk;
      end
   endtask
   initial begin
      #2000000;
      errors++;
      give_verdict();
   end
   initial begin
      seed = 37;
      errors = 0;
      comparisons = 0;
      rstn = 1'b0;
      clkEn = 1'b1;
      strap = 2'h1;
      pin = {13'h0000, strap};
      cA = 8'h00;
      cB = 8'h00;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      @(negedge clk_sys);
      check_val("fault after reset", 1'b1, fOe);
      check_all();
      // write while frozen must be lost
      @(posedge clk_sys);
      clkEn <= 1'b0;
      host.write_reg(3'h0, 8'hff);
      clkEn <= 1'b1;
      check_all();
      host.write_reg(3'h2, 8'hff);
      host.write_reg(3'h3, 8'hff);
      host.read_reg(3'h3, rd);
      check_val("slaveReg", {6'h02, strap}, rd);
      for (int i = 4; i < 8; i++) begin
         host.read_reg(i[2:0], rd);
         check_val("unmapped", 8'h00, rd);
      end
      for (int i = 0; i < 306; i++) begin
         n = $random(seed);
         nb = $random(seed);
         @(posedge clk_sys);
         // straps held: they are caught once after reset
         pin <= {n[14:10] & n[20:16] & n[25:21], n[9:2], strap};
         cA = (i < 6) ? corner[i] : nb[7:0];
         cB = (i < 6) ? ~corner[i] : nb[15:8];
         host.write_reg(3'h0, cA);
         host.write_reg(3'h1, cB);
         check_all();
      end
      // mid-run reset with other straps: controls clear, new address taken
      @(posedge clk_sys);
      rstn <= 1'b0;
      strap = 2'h2;
      pin <= {13'h0000, strap};
      cA = 8'h00;
      cB = 8'h00;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      @(negedge clk_sys);
      check_val("fault after reset", 1'b1, fOe);
      check_all();
      // envelope burst gates the internal tone, continuous bit kept low
      @(posedge clk_sys);
      pin <= {11'h000, 2'b01, strap};
      cA = 8'h01;
      host.write_reg(3'h0, cA);
      repeat (3) @(negedge clk_sys);
      wait_toggle(n, nb);
      wait_toggle(n, nb);
      check_val("gated half period", 16'd900, n[15:0]);
      // continuous tone with the envelope pin idle
      @(posedge clk_sys);
      pin <= {13'h0000, strap};
      cA = 8'h03;
      host.write_reg(3'h0, cA);
      repeat (3) @(negedge clk_sys);
      wait_toggle(n, nb);
      wait_toggle(n, nb);
      check_val("tone half period", 16'd900, n[15:0]);
      check_val("boost edges", 16'd20, nb[15:0]);
      give_verdict();
   end
endmodule // tb_top
